/* verilog/sync_iq_correction_regs.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [RULE_01] Master enable gates every sync function
// [RULE_02] Pulses reach divider only with bits 0,1
// [RULE_03] Bit 2 low: resync on every pulse
// [RULE_04] Bit 2 high: first pulse only
// [RULE_05] Divider sync enable self-clears after syncing
// [RULE_06] Bit 7 decides whether enable pin counts
// [RULE_07] Detect bit starts oscillator below 5 MSPS
// [RULE_08] Run bit forces the helper oscillator on
// [RULE_09] Bit 0 disconnects serial data pull-down
// [RULE_10] Freeze bits hold terms, stop estimation
// [RULE_11] Enable bits apply DC, phase, gain terms
// [RULE_12] Force DC uses preset I and Q values
// [RULE_13] Force phase uses preset phase value
// [RULE_14] Force gain uses preset gain value
// [RULE_15] Five-bit gain loop time constant
// [RULE_16] Five-bit phase loop time constant
// [RULE_17] Five-bit DC loop time constant
// [RULE_18] Preset gain: 15 bits, low byte first
// [RULE_19] Preset phase: 13 bits, low byte first
// [RULE_20] Preset DC I, Q: 14 bits each
// [RULE_21] Host keeps serial port quiet when sampling
// [RULE_22] Open bits read zero, ignore writes
module sync_iq_correction_regs
  import iq_sync_pkg::*;
(
  input wire logic clk, // 125 MHz
  input wire logic rst, // Synchronous, active high
  input serial_in_t ser_in, // Serial port pins, asynchronous
  output logic sdio_out, // Serial read data
  output logic sdio_oe, // High while driving serial data
  output logic sdio_pulldown_on, // Pull-down connected
  input wire logic sync_pin, // External sync pulse
  output logic divider_resync, // One-cycle divider realign
  input wire logic encode_pin, // Encode clock, sampled
  output logic helper_osc_run, // Low-rate helper oscillator on
  input wire logic output_enable_pin_n, // Output enable pin
  output logic outputs_enabled, // Data outputs driven
  input iq_sample_t in_sample, // Raw I/Q sample
  input wire logic in_valid, // Sample strobe
  output iq_sample_t out_sample, // Corrected sample
  output logic out_valid // Corrected sample strobe
);

  // ==========================================
  // State
  typedef struct packed {
    logic [14:0][7:0] bank;
    logic [2:0] sclk_s;
    logic [2:0] csb_s;
    logic [1:0] sdio_s;
    logic [2:0] sync_s;
    logic [2:0] enc_s;
    logic [1:0] oe_s;
    ser_phase_t phase;
    logic [3:0] bit_cnt;
    logic rd;
    logic [12:0] addr;
    logic [15:0] shift_in;
    logic [7:0] shift_out;
    logic sdio_oe;
    logic [7:0] enc_gap;
    logic low_rate;
    logic helper_run;
    logic outs_en;
    logic pd_on;
    logic resync;
    logic signed [31:0] dc_i_acc;
    logic signed [31:0] dc_q_acc;
    logic signed [31:0] gain_acc;
    logic signed [31:0] phase_acc;
    iq_sample_t out;
    logic out_valid;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ==========================================
  // Helpers
  function automatic logic [4:0] find_reg(input logic [12:0] a);
    logic [4:0] r;
    r = 5'h00;
    for (int k = 0; k < REG_COUNT; k++) begin
      if (REG_ADDR[k] == a) begin
        r = {1'b1, 4'(k)};
      end
    end
    return r;
  endfunction

  // Unmapped addresses read as zero
  function automatic logic [7:0] read_reg(input state_t s, input logic [12:0] a);
    logic [4:0] h;
    h = find_reg(a);
    return h[4] ? s.bank[h[3:0]] : 8'h00;
  endfunction

  // Leaky loop: larger time constant, slower loop
  function automatic logic signed [31:0] leak(input logic signed [31:0] acc,
      input logic signed [15:0] err, input logic [4:0] k);
    logic signed [31:0] e;
    e = 32'(err) <<< 16;
    return acc + (e >>> k);
  endfunction

  function automatic logic signed [15:0] mul_sh(input logic signed [15:0] a,
      input logic signed [15:0] b, input logic [3:0] sh);
    logic signed [31:0] p;
    p = a * b;
    return 16'(p >>> sh);
  endfunction

  function automatic logic signed [15:0] mag(input logic signed [15:0] a);
    return a[15] ? 16'(-a) : a;
  endfunction

  // ==========================================
  // Decoded controls
  logic sync_master, sync_div, sync_next, sync_rise, sync_fire;
  logic [5:0] corr_a;
  logic [2:0] corr_b;
  logic signed [15:0] gain_pre, phase_pre, dci_pre, dcq_pre;
  logic signed [15:0] dci_use, dcq_use, gain_use, phase_use;
  logic signed [15:0] i1, q1, q2, q3;
  logic sclk_rise;
  logic [15:0] instr;
  logic [4:0] hit;

  assign sync_master = st_reg.bank[IDX_SYNC][SYNC_MASTER_BIT];
  assign sync_div = st_reg.bank[IDX_SYNC][SYNC_DIV_BIT];
  assign sync_next = st_reg.bank[IDX_SYNC][SYNC_NEXT_BIT];
  assign sync_rise = st_reg.sync_s[1] & ~st_reg.sync_s[2];
  assign sync_fire = sync_rise & sync_master & sync_div; // RULE_01 RULE_02
  assign corr_a = st_reg.bank[IDX_CORR_A][5:0];
  assign corr_b = st_reg.bank[IDX_CORR_B][2:0];
  assign gain_pre = {st_reg.bank[IDX_GAIN_HI][6], st_reg.bank[IDX_GAIN_HI][6:0],
                     st_reg.bank[IDX_GAIN_LO]}; // RULE_18
  assign phase_pre = {{3{st_reg.bank[IDX_PHASE_HI][4]}}, st_reg.bank[IDX_PHASE_HI][4:0],
                      st_reg.bank[IDX_PHASE_LO]}; // RULE_19
  assign dci_pre = {{2{st_reg.bank[IDX_DCI_HI][5]}}, st_reg.bank[IDX_DCI_HI][5:0],
                    st_reg.bank[IDX_DCI_LO]}; // RULE_20
  assign dcq_pre = {{2{st_reg.bank[IDX_DCQ_HI][5]}}, st_reg.bank[IDX_DCQ_HI][5:0],
                    st_reg.bank[IDX_DCQ_LO]}; // RULE_20

  // Forced presets replace the loop estimates
  assign dci_use = corr_b[TERM_DC] ? dci_pre : st_reg.dc_i_acc[31:16]; // RULE_12
  assign dcq_use = corr_b[TERM_DC] ? dcq_pre : st_reg.dc_q_acc[31:16]; // RULE_12
  assign gain_use = corr_b[TERM_GAIN] ? gain_pre : st_reg.gain_acc[31:16]; // RULE_14
  assign phase_use = corr_b[TERM_PHASE] ? phase_pre : st_reg.phase_acc[31:16]; // RULE_13

  // Disabled terms pass the sample through untouched
  assign i1 = corr_a[TERM_DC] ? 16'(in_sample.i - dci_use) : in_sample.i; // RULE_11
  assign q1 = corr_a[TERM_DC] ? 16'(in_sample.q - dcq_use) : in_sample.q; // RULE_11
  assign q2 = corr_a[TERM_GAIN] ? 16'(q1 + mul_sh(q1, gain_use, 4'hE)) : q1; // RULE_11
  assign q3 = corr_a[TERM_PHASE] ? 16'(q2 - mul_sh(i1, phase_use, 4'hC)) : q2; // RULE_11

  assign sclk_rise = st_reg.sclk_s[1] & ~st_reg.sclk_s[2];
  assign instr = {st_reg.shift_in[14:0], st_reg.sdio_s[1]};
  assign hit = find_reg(st_reg.addr);

  // ==========================================
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.sclk_s = {st_reg.sclk_s[1:0], ser_in.sclk};
    st_next.csb_s = {st_reg.csb_s[1:0], ser_in.csb_n};
    st_next.sdio_s = {st_reg.sdio_s[0], ser_in.sdio};
    st_next.sync_s = {st_reg.sync_s[1:0], sync_pin};
    st_next.enc_s = {st_reg.enc_s[1:0], encode_pin};
    st_next.oe_s = {st_reg.oe_s[0], output_enable_pin_n};

    // Sync gating; the self-clear comes before any host write so a set wins
    st_next.resync = sync_fire; // RULE_03
    if (sync_fire && sync_next) begin
      st_next.bank[IDX_SYNC][SYNC_DIV_BIT] = 1'b0; // RULE_04 RULE_05
    end

    // Serial port: 16-bit instruction, then bytes with descending address
    if (st_reg.csb_s[1]) begin
      st_next.phase = SER_IDLE;
      st_next.bit_cnt = 4'h0;
      st_next.sdio_oe = 1'b0;
    end else begin
      unique case (st_reg.phase)
        SER_IDLE: begin
          st_next.phase = SER_INSTR;
          st_next.bit_cnt = 4'h0;
        end
        SER_INSTR: begin
          if (sclk_rise) begin
            st_next.shift_in = instr;
            st_next.bit_cnt = 4'(st_reg.bit_cnt + 4'h1);
            if (st_reg.bit_cnt == INSTR_LAST) begin
              st_next.phase = SER_DATA;
              st_next.rd = instr[15];
              st_next.addr = instr[12:0];
              st_next.shift_out = read_reg(st_reg, instr[12:0]);
              st_next.sdio_oe = instr[15];
            end
          end
        end
        SER_DATA: begin
          if (sclk_rise) begin
            st_next.shift_in = instr;
            st_next.shift_out = {st_reg.shift_out[6:0], 1'b0};
            st_next.bit_cnt = 4'(st_reg.bit_cnt + 4'h1);
            if (st_reg.bit_cnt == BYTE_LAST) begin
              st_next.bit_cnt = 4'h0;
              st_next.addr = st_reg.addr - 13'h0001;
              if (st_reg.rd) begin
                st_next.shift_out = read_reg(st_reg, st_reg.addr - 13'h0001);
              end else if (hit[4]) begin
                st_next.bank[hit[3:0]] = instr[7:0] & REG_MASK[hit[3:0]]; // RULE_22
              end
            end
          end
        end
      endcase
    end

    // Encode rate watch: a long gap between edges means a slow clock
    if (st_reg.enc_s[1] && !st_reg.enc_s[2]) begin
      st_next.enc_gap = 8'h00;
    end else if (st_reg.enc_gap != 8'hFF) begin
      st_next.enc_gap = st_reg.enc_gap + 8'h01;
    end
    st_next.low_rate = st_reg.enc_gap >= LOW_RATE_CYC;
    st_next.helper_run = st_reg.bank[IDX_USER2][U2_RUN_BIT] // RULE_08
      | (st_reg.bank[IDX_USER2][U2_DETECT_BIT] & st_reg.low_rate); // RULE_07
    st_next.outs_en = st_reg.bank[IDX_USER2][U2_OE_BIT] ? ~st_reg.oe_s[1] : 1'b1; // RULE_06
    st_next.pd_on = ~st_reg.bank[IDX_USER2][U2_PULLDOWN_BIT]; // RULE_09

    // Correction datapath and estimation loops
    st_next.out_valid = in_valid;
    if (in_valid) begin
      st_next.out.i = i1;
      st_next.out.q = q3;
      if (corr_a[TERM_DC] && !corr_a[FREEZE_LSB + TERM_DC]) begin // RULE_10
        st_next.dc_i_acc = leak(st_reg.dc_i_acc, 16'(in_sample.i - st_reg.dc_i_acc[31:16]),
                                st_reg.bank[IDX_BW_DC][4:0]); // RULE_17
        st_next.dc_q_acc = leak(st_reg.dc_q_acc, 16'(in_sample.q - st_reg.dc_q_acc[31:16]),
                                st_reg.bank[IDX_BW_DC][4:0]); // RULE_17
      end
      if (corr_a[TERM_GAIN] && !corr_a[FREEZE_LSB + TERM_GAIN]) begin // RULE_10
        st_next.gain_acc = leak(st_reg.gain_acc, 16'(mag(i1) - mag(q2)),
                                st_reg.bank[IDX_BW_GAIN][4:0]); // RULE_15
      end
      if (corr_a[TERM_PHASE] && !corr_a[FREEZE_LSB + TERM_PHASE]) begin // RULE_10
        st_next.phase_acc = leak(st_reg.phase_acc, mul_sh(i1, q3, 4'hF),
                                 st_reg.bank[IDX_BW_PHASE][4:0]); // RULE_16
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.bank <= REG_RESET;
      st_reg.csb_s <= 3'h7;
      st_reg.phase <= SER_IDLE;
      st_reg.outs_en <= 1'b1;
      st_reg.pd_on <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================
  // Outputs
  // Read data changes a few cycles after the host's rising edge,
  // so the serial clock must stay well below the system clock.
  assign sdio_out = st_reg.shift_out[7];
  assign sdio_oe = st_reg.sdio_oe;
  assign sdio_pulldown_on = st_reg.pd_on;
  assign divider_resync = st_reg.resync;
  assign helper_osc_run = st_reg.helper_run;
  assign outputs_enabled = st_reg.outs_en;
  assign out_sample = st_reg.out;
  assign out_valid = st_reg.out_valid;

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_pulse_seen;
    st_reg.sync_s[1] && !st_reg.sync_s[2];
  endsequence

  sequence s_gate_open;
    sync_master && sync_div;
  endsequence

  a_master_gate: assert property ( // RULE_01
    divider_resync |-> $past(sync_master) && $past(sync_rise))
    else $error("divider resync without master enable");

  a_sync_blocked: assert property ( // RULE_02
    !(sync_master && sync_div) |=> !divider_resync)
    else $error("divider resync with gate closed");

  a_continuous_sync: assert property ( // RULE_03
    (s_pulse_seen and s_gate_open) ##0 !sync_next |=> divider_resync)
    else $error("pulse not passed in continuous mode");

  a_one_shot_clear: assert property ( // RULE_05
    (s_pulse_seen and s_gate_open) ##0 sync_next |=> divider_resync && !sync_div)
    else $error("one-shot sync did not clear enable");

  a_oe_ignored: assert property ( // RULE_06
    !st_reg.bank[IDX_USER2][U2_OE_BIT] |=> outputs_enabled)
    else $error("enable pin not ignored");

  a_helper_forced: assert property ( // RULE_08
    st_reg.bank[IDX_USER2][U2_RUN_BIT] |=> helper_osc_run)
    else $error("helper oscillator not forced");

  a_detect_off: assert property ( // RULE_07
    !st_reg.bank[IDX_USER2][U2_RUN_BIT] && !st_reg.bank[IDX_USER2][U2_DETECT_BIT]
    |=> !helper_osc_run)
    else $error("helper oscillator on with detector off");

  a_pulldown_ctrl: assert property ( // RULE_09
    st_reg.bank[IDX_USER2][U2_PULLDOWN_BIT] |=> !sdio_pulldown_on)
    else $error("pull-down not disconnected");

  a_gain_frozen: assert property ( // RULE_10
    corr_a[FREEZE_LSB + TERM_GAIN] |=> st_reg.gain_acc == $past(st_reg.gain_acc))
    else $error("gain estimate moved while frozen");

  a_dc_bypass: assert property ( // RULE_11
    in_valid && !corr_a[TERM_DC] |=> out_valid && out_sample.i == $past(in_sample.i))
    else $error("I sample altered with DC term off");

  a_force_dc: assert property ( // RULE_12
    in_valid && corr_a[TERM_DC] && corr_b[TERM_DC]
    |=> out_sample.i == 16'($past(in_sample.i) - $past(dci_pre)))
    else $error("forced DC preset not applied to I");

  a_reserved_zero: assert property ( // RULE_22
    st_reg.bank[IDX_SYNC][7:3] == 5'h00 && st_reg.bank[IDX_USER2][6:4] == 3'h0)
    else $error("open bits not zero");

endmodule

/* verilog/iq_sync_pkg.sv */
package iq_sync_pkg;
  // ==========================================
  // Register map
  localparam int ADDR_W = 13;
  localparam int REG_COUNT = 15;
  localparam logic [3:0] IDX_SYNC = 4'h0;
  localparam logic [3:0] IDX_USER2 = 4'h1;
  localparam logic [3:0] IDX_CORR_A = 4'h2;
  localparam logic [3:0] IDX_CORR_B = 4'h3;
  localparam logic [3:0] IDX_BW_GAIN = 4'h4;
  localparam logic [3:0] IDX_BW_PHASE = 4'h5;
  localparam logic [3:0] IDX_BW_DC = 4'h6;
  localparam logic [3:0] IDX_GAIN_LO = 4'h7;
  localparam logic [3:0] IDX_GAIN_HI = 4'h8;
  localparam logic [3:0] IDX_PHASE_LO = 4'h9;
  localparam logic [3:0] IDX_PHASE_HI = 4'hA;
  localparam logic [3:0] IDX_DCI_LO = 4'hB;
  localparam logic [3:0] IDX_DCI_HI = 4'hC;
  localparam logic [3:0] IDX_DCQ_LO = 4'hD;
  localparam logic [3:0] IDX_DCQ_HI = 4'hE;
  // Entry n belongs to index n
  localparam logic [14:0][12:0] REG_ADDR = {
    13'h11D, 13'h11C, 13'h11B, 13'h11A, 13'h119, 13'h118, 13'h117, 13'h116,
    13'h114, 13'h113, 13'h112, 13'h111, 13'h110, 13'h101, 13'h100};
  // Writable bits; the rest hold zero
  localparam logic [14:0][7:0] REG_MASK = {
    8'h3F, 8'hFF, 8'h3F, 8'hFF, 8'h1F, 8'hFF, 8'h7F, 8'hFF,
    8'h1F, 8'h1F, 8'h1F, 8'h07, 8'h3F, 8'h8D, 8'h07};
  localparam logic [14:0][7:0] REG_RESET = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h88, 8'h01};
  // ==========================================
  // Field positions
  localparam int SYNC_MASTER_BIT = 0;
  localparam int SYNC_DIV_BIT = 1;
  localparam int SYNC_NEXT_BIT = 2;
  localparam int U2_PULLDOWN_BIT = 0;
  localparam int U2_RUN_BIT = 2;
  localparam int U2_DETECT_BIT = 3;
  localparam int U2_OE_BIT = 7;
  localparam int TERM_GAIN = 0;
  localparam int TERM_PHASE = 1;
  localparam int TERM_DC = 2;
  localparam int FREEZE_LSB = 3;
  // ==========================================
  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int LOW_RATE_NS = 200;
  localparam logic [7:0] LOW_RATE_CYC = 8'(LOW_RATE_NS / CLK_PERIOD_NS);
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  // ==========================================
  // Types
  typedef enum logic [1:0] {SER_IDLE, SER_INSTR, SER_DATA} ser_phase_t;
  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } iq_sample_t;
  typedef struct packed {
    logic sclk;
    logic csb_n;
    logic sdio;
  } serial_in_t;
endpackage

/* verification/spi_host_model.sv */
`timescale 1ns/1ps
module spi_host_model
  import iq_sync_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic sdio_out, // Device read data
  input wire logic sdio_oe, // Device drives data
  input wire logic sdio_pulldown_on, // Pull-down connected
  output serial_in_t ser, // Pins toward device
  output logic [7:0] rd_data, // Last byte read
  output logic rd_done // One-cycle read strobe
);
  logic host_oe = 1'b0;
  logic host_bit = 1'b0;
  logic sclk = 1'b0;
  logic csb_n = 1'b1;
  logic last_lvl = 1'b0;
  logic line;
  // Undriven line without pull-down flips every cycle so stale data never passes
  assign line = (sdio_oe === 1'b1) ? sdio_out : host_oe ? host_bit :
                (sdio_pulldown_on !== 1'b0) ? 1'b0 : ~last_lvl;
  assign ser = '{sclk: sclk, csb_n: csb_n, sdio: line};
  always @(posedge clk) last_lvl <= line;
  initial begin
    rd_data = 8'h00;
    rd_done = 1'b0;
  end
  // Phases of 6 cycles keep sclk well under the device's sampling limit
  task automatic bit_io(input logic b, output logic s);
    host_bit <= b;
    repeat (6) @(posedge clk);
    s = line;
    sclk <= 1'b1;
    repeat (6) @(posedge clk);
    sclk <= 1'b0;
  endtask
  // Between frames sclk and csb_n stand still so sampling is not disturbed
  task automatic xfer(input logic rd, input logic [12:0] addr, input logic [7:0] wdat);
    logic [15:0] ins;
    logic [7:0] got;
    logic s;
    ins = {rd, 2'b00, addr};
    @(posedge clk);
    csb_n <= 1'b0;
    host_oe <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 15; k >= 0; k--) bit_io(ins[k], s);
    host_oe <= !rd;
    for (int k = 7; k >= 0; k--) begin
      bit_io(wdat[k], s);
      got[k] = s;
    end
    repeat (6) @(posedge clk);
    csb_n <= 1'b1;
    host_oe <= 1'b0;
    if (rd) begin
      rd_data <= got;
      rd_done <= 1'b1;
      @(posedge clk);
      rd_done <= 1'b0;
    end
    repeat (6) @(posedge clk);
  endtask
endmodule

/* verification/sync_iq_correction_regs_tb_top.sv */
`timescale 1ns/1ps
module sync_iq_correction_regs_tb_top
  import iq_sync_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sync_pin = 1'b0, encode_pin = 1'b0, oe_pin_n = 1'b0, in_valid = 1'b0, enc_run = 1'b1;
  iq_sample_t in_sample = '0;
  serial_in_t ser;
  logic sdio_out, sdio_oe, pd_on, resync, osc_run, outs_en, out_valid, rd_done;
  logic [7:0] rd_data;
  iq_sample_t out_sample;
  int err_total = 0, num_checks = 0, cyc = 0;
  logic [31:0] seed = 32'h00008EB0;
  logic [7:0] rd_q[$];
  iq_sample_t smp_q[$];
  logic [31:0] sync_q[$];
  logic [7:0] wv [15];
  logic [7:0] scfg [6] = '{8'h00, 8'h02, 8'h01, 8'h05, 8'h03, 8'h07};
  logic [7:0] srb [6] = '{8'h00, 8'h02, 8'h01, 8'h05, 8'h03, 8'h05};
  int snum [6] = '{0, 0, 0, 0, 2, 1};
  logic [7:0] pre [8] = '{8'h00, 8'h20, 8'h00, 8'h08, 8'h10, 8'h00, 8'hF0, 8'h3F};
  logic [2:0] modes [5] = '{3'h0, 3'h4, 3'h1, 3'h2, 3'h7};

  always #4 clk = ~clk;
  always @(posedge clk) if (enc_run) encode_pin <= ~encode_pin;

  sync_iq_correction_regs i_sync_iq_correction_regs (.clk(clk), .rst(rst), .ser_in(ser),
    .sdio_out(sdio_out), .sdio_oe(sdio_oe), .sdio_pulldown_on(pd_on), .sync_pin(sync_pin),
    .divider_resync(resync), .encode_pin(encode_pin), .helper_osc_run(osc_run),
    .output_enable_pin_n(oe_pin_n), .outputs_enabled(outs_en), .in_sample(in_sample),
    .in_valid(in_valid), .out_sample(out_sample), .out_valid(out_valid));
  spi_host_model i_spi_host_model (.clk(clk), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .sdio_pulldown_on(pd_on), .ser(ser), .rd_data(rd_data), .rd_done(rd_done));

  // ==========================================
  // Checking
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      stop_test();
    end
  end
  // Each result takes the oldest note of its own stream
  always @(posedge clk) begin
    if (rd_done) begin
      if (rd_q.size() == 0) chk("read_extra", 32'h1, 32'h0);
      else chk("read_data", 32'(rd_data), 32'(rd_q.pop_front()));
    end
    if (out_valid) begin
      if (smp_q.size() == 0) chk("sample_extra", 32'h1, 32'h0);
      else chk("out_sample", out_sample, smp_q.pop_front());
    end
    if (resync) begin
      if (sync_q.size() == 0) chk("resync_extra", 32'h1, 32'h0);
      else chk("divider_resync", 32'($time), sync_q.pop_front());
    end
  end

  // ==========================================
  // Stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    i_spi_host_model.xfer(1'b0, a, d);
  endtask
  task automatic rd(input logic [12:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    i_spi_host_model.xfer(1'b1, a, 8'h00);
  endtask
  // A passed pulse shows four edges after the pin edge: two sync flops,
  // the output register and the edge at which the bench samples it
  task automatic pulse_sync(input logic pass);
    @(posedge clk);
    if (pass) sync_q.push_back(32'($time) + 32'(4 * CLK_PERIOD_NS));
    sync_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sync_pin <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic level(input logic [7:0] u2, input logic pin_n, input logic [2:0] e);
    wr(13'h101, u2);
    @(posedge clk);
    oe_pin_n <= pin_n;
    repeat (6) @(posedge clk);
    chk("pulldown_on", 32'(pd_on), 32'(e[2]));
    chk("outputs_enabled", 32'(outs_en), 32'(e[1]));
    chk("helper_osc_run", 32'(osc_run), 32'(e[0]));
  endtask
  // Forced presets: DC I 16, DC Q -16, gain 8192, phase 2048
  task automatic send(input logic [2:0] a, input int n);
    logic [31:0] r;
    int i, q, i1, q1, q2;
    for (int k = 0; k < n; k++) begin
      r = rnd();
      i = int'($signed(r[12:0]));
      q = int'($signed(r[28:16]));
      i1 = a[2] ? i - 16 : i;
      q1 = a[2] ? q + 16 : q;
      q2 = a[0] ? q1 + ((q1 * 8192) >>> 14) : q1;
      q2 = a[1] ? q2 - ((i1 * 2048) >>> 12) : q2;
      smp_q.push_back('{i: 16'(i1), q: 16'(q2)});
      @(posedge clk);
      in_sample <= '{i: 16'(i), q: 16'(q)};
      in_valid <= 1'b1;
    end
    @(posedge clk);
    in_valid <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int n = 0; n < REG_COUNT; n++) rd(REG_ADDR[n], REG_RESET[n]);
    wr(13'h115, 8'hFF);
    rd(13'h115, 8'h00);
    for (int n = 0; n < REG_COUNT; n++) begin
      wv[n] = 8'(rnd());
      wr(REG_ADDR[n], wv[n]);
    end
    for (int n = 0; n < REG_COUNT; n++) rd(REG_ADDR[n], wv[n] & REG_MASK[n]);
    for (int t = 0; t < 6; t++) begin
      wr(13'h100, scfg[t]);
      for (int p = 0; p < 2; p++) begin
        pulse_sync(p < snum[t]);
      end
      chk("resync_missing", 32'(sync_q.size()), 32'h0);
      rd(13'h100, srb[t]);
    end
    level(8'h00, 1'b1, 3'b110);
    level(8'h81, 1'b1, 3'b000);
    level(8'h81, 1'b0, 3'b010);
    level(8'h04, 1'b0, 3'b111);
    level(8'h08, 1'b0, 3'b110);
    enc_run <= 1'b0;
    repeat (40) @(posedge clk);
    chk("helper_slow", 32'(osc_run), 32'h1);
    wr(13'h111, 8'h00);
    wr(13'h110, 8'h3F);
    send(3'h0, 8);
    for (int n = 0; n < 8; n++) wr(13'h116 + 13'(n), pre[n]);
    wr(13'h111, 8'h07);
    for (int m = 0; m < 5; m++) begin
      wr(13'h110, 8'(modes[m]));
      send(modes[m], 6);
    end
    repeat (20) @(posedge clk);
    chk("pending", 32'(rd_q.size() + smp_q.size()), 32'h0);
    stop_test();
  end
endmodule
